// [rsci_defs.svh]
/*
  Constants for the radio state, command and event aggregation block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 25 MHz core clock; included by bare name where needed.
*/
`ifndef RSCI_DEFS_SVH
`define RSCI_DEFS_SVH

// register offsets on the serial register port (one byte address each)
`define RSCI_OFS_RF_STATUS0 8'h00
`define RSCI_OFS_RF_STATUS1 8'h01
`define RSCI_OFS_BB_STATUS0 8'h02
`define RSCI_OFS_BB_STATUS1 8'h03
`define RSCI_OFS_CFG 8'h06
`define RSCI_OFS_RF_MASK0 8'h10
`define RSCI_OFS_RF_MASK1 8'h11
`define RSCI_OFS_BB_MASK0 8'h12
`define RSCI_OFS_BB_MASK1 8'h13
`define RSCI_OFS_STATE0 8'h20
`define RSCI_OFS_STATE1 8'h21
`define RSCI_OFS_CMD0 8'h22
`define RSCI_OFS_CMD1 8'h23

// state codes read back
`define RSCI_ST_OFF 3'h2
`define RSCI_ST_PREP 3'h3
`define RSCI_ST_TX 3'h4
`define RSCI_ST_RX 3'h5
`define RSCI_ST_TRANS 3'h6
`define RSCI_ST_RESET 3'h7

// command codes
`define RSCI_CMD_NOP 3'h0
`define RSCI_CMD_SLEEP 3'h1
`define RSCI_CMD_OFF 3'h2
`define RSCI_CMD_PREP 3'h3
`define RSCI_CMD_TX 3'h4
`define RSCI_CMD_RX 3'h5
`define RSCI_CMD_RESET 3'h7

// radio status fields
`define RSCI_RF_WAKE 0
`define RSCI_RF_READY 1
`define RSCI_RF_EDONE 2
`define RSCI_RF_LOW_BATTERY 3
`define RSCI_RF_LOCKERR 4
`define RSCI_RF_SYNCFAIL 5
// baseband status fields
`define RSCI_BB_EMATCH 3
`define RSCI_BB_TXEND 4
`define RSCI_BB_GHOLD 5
`define RSCI_BB_GREL 6
`define RSCI_BB_BUFLVL 7
// configuration fields
`define RSCI_CFG_RAW 0
`define RSCI_CFG_MASKMODE 3

// reset values
`define RSCI_RF_MASK_RST 8'h01
`define RSCI_BB_MASK_RST 8'h00
`define RSCI_CFG_RST 8'h00
`define RSCI_CMD_RST 8'h00

// state change time and its cycle count at 40 ns (least time, rounded up)
`define RSCI_TRANS_NS 200
`define RSCI_CLK_NS 40
`define RSCI_TRANS_CYC ((`RSCI_TRANS_NS + `RSCI_CLK_NS - 1) / `RSCI_CLK_NS)

`endif

// [rsci_pkg.sv]
/*
  Types for the radio state, command and event aggregation block.
  Assumes rsci_defs.svh supplies the numeric constants.
*/
package rsci_pkg;
  // per-radio event inputs from the radio front end
  typedef struct packed {
    logic sync_fail;
    logic lock_err;
    logic energy_done;
  } rsci_rf_evt_s;

  // internal radio condition, binary codes written out
  typedef enum logic [2:0] {
    RSCI_RESET = 3'h0,
    RSCI_SLEEP = 3'h1,
    RSCI_OFF = 3'h2,
    RSCI_PREP = 3'h3,
    RSCI_TX = 3'h4,
    RSCI_RX = 3'h5
  } rsci_cond_e;

  typedef logic [7:0] rsci_byte_t;
endpackage

// [rsci_radio_fsm.sv]
/*
  One radio's state sequencer with its one-entry command queue.
  Assumes the parent delivers single-cycle command write strobes.
*/
`include "rsci_defs.svh"

module rsci_radio_fsm import rsci_pkg::*; (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic cmd_wr_in,
  input wire logic [2:0] cmd_in,
  input wire logic wake_all_in,
  output logic [2:0] state_out,
  output logic asleep_out,
  output logic wake_evt_out,
  output logic ready_evt_out
);
  localparam logic [3:0] TRANS_CYC = 4'(`RSCI_TRANS_CYC);

  rsci_cond_e cur_ff;
  rsci_cond_e tgt_ff;
  logic busy_ff;
  logic [3:0] cnt_ff;
  logic pend_v_ff;
  logic [2:0] pend_ff;
  logic wake_ff;
  logic ready_ff;
  logic launch;
  logic legal;

  // defined codes only
  // sleeping radios accept only the off command; transition code is never a target
  assign legal = (cur_ff == RSCI_SLEEP) ? (pend_ff == `RSCI_CMD_OFF) :
                 (pend_ff != `RSCI_CMD_NOP) && (pend_ff != 3'h6);
  assign launch = !busy_ff && pend_v_ff;

  // one-entry queue
  // a newer write overwrites the queued one; it runs after the current change ends
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_v_ff <= 1'b0;
      pend_ff <= `RSCI_CMD_NOP;
    end else if (ce_in) begin
      if (wake_all_in) begin
        pend_v_ff <= 1'b1;
        pend_ff <= `RSCI_CMD_OFF;
      end else if (cmd_wr_in) begin
        pend_v_ff <= 1'b1;
        pend_ff <= cmd_in;
      end else if (launch) begin
        pend_v_ff <= 1'b0;
      end
    end
  end

  // reset then off
  // power-up starts in reset and busy, so every chip reset ends in off with a wake pulse
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_ff <= RSCI_RESET;
      tgt_ff <= RSCI_OFF;
      busy_ff <= 1'b1;
      cnt_ff <= TRANS_CYC;
      wake_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (ce_in) begin
      wake_ff <= 1'b0;
      ready_ff <= 1'b0;
      if (busy_ff) begin
        if (cnt_ff <= 4'h1) begin
          busy_ff <= 1'b0;
          cur_ff <= tgt_ff;
          // wake flag after reset or sleep
          wake_ff <= (tgt_ff == RSCI_OFF) &&
                     ((cur_ff == RSCI_RESET) || (cur_ff == RSCI_SLEEP));
          ready_ff <= (tgt_ff == RSCI_PREP);
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end else if (launch && legal) begin
        busy_ff <= 1'b1;
        cnt_ff <= TRANS_CYC;
        if (pend_ff == `RSCI_CMD_RESET) begin
          cur_ff <= RSCI_RESET;
          tgt_ff <= RSCI_OFF;
        end else begin
          tgt_ff <= rsci_cond_e'(pend_ff);
        end
      end
    end
  end

  // reset and sleep both read as the reset code
  always_comb begin
    if (cur_ff == RSCI_RESET || cur_ff == RSCI_SLEEP) begin
      state_out = `RSCI_ST_RESET;
    end else if (busy_ff) begin
      state_out = `RSCI_ST_TRANS;
    end else begin
      state_out = 3'(cur_ff);
    end
  end

  assign asleep_out = (cur_ff == RSCI_SLEEP) || (cur_ff == RSCI_RESET);
  assign wake_evt_out = wake_ff;
  assign ready_evt_out = ready_ff;

  // busy away from sleep reads transition
  chk_busy_reads_trans: assert property (@(posedge clock_in) disable iff (!resetn_in)
    busy_ff && !asleep_out |-> state_out == `RSCI_ST_TRANS)
    else $error("busy radio does not read transition code");

  chk_reset_to_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ce_in && launch && legal && pend_ff == `RSCI_CMD_RESET && !cmd_wr_in && !wake_all_in
    |=> (ce_in && !cmd_wr_in && !wake_all_in) [*5] |=> state_out == `RSCI_ST_OFF)
    else $error("reset command did not end in off");
endmodule // rsci_radio_fsm

// [rsci_top.sv]
/*
  Radio state/command registers and event aggregation for two radios
  and two baseband cores, reached over the serial register port.
  Assumes the serial interface delivers one-cycle read and write
  strobes synchronous to clock_in; a burst is a run of such reads.
*/
`include "rsci_defs.svh"

module rsci_top import rsci_pkg::*; (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire rsci_rf_evt_s [1:0] rf_evt_in,
  input wire logic low_battery_in,
  input wire logic [1:0][7:0] bb_evt_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out
);
  rsci_byte_t rf_stat_ff [2];
  rsci_byte_t bb_stat_ff [2];
  rsci_byte_t rf_mask_ff [2];
  rsci_byte_t bb_mask_ff [2];
  rsci_byte_t cmd_ff [2];
  rsci_byte_t cfg_ff;
  rsci_byte_t rdata_ff;
  logic irq_ff;
  logic [2:0] state [2];
  logic [1:0] asleep;
  logic [1:0] wake_evt;
  logic [1:0] ready_evt;
  logic [1:0] cmd_wr;
  logic [1:0] wake_all;
  logic [1:0] rf_clr;
  logic [1:0] bb_clr;
  rsci_byte_t rf_raw [2];
  rsci_byte_t rf_rec [2];
  rsci_byte_t bb_rec [2];
  logic raw_mode;
  logic mask_mode;
  logic deep_sleep;
  logic nxt_irq;

  assign raw_mode = cfg_ff[`RSCI_CFG_RAW];
  assign mask_mode = cfg_ff[`RSCI_CFG_MASKMODE];
  assign deep_sleep = &asleep;

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_chan
      // write strobe of the command register
      assign cmd_wr[n] = reg_wr_in && reg_addr_in == (`RSCI_OFS_CMD0 + 8'(n));
      // an off command to either radio in deep sleep wakes the other one too
      assign wake_all[n] = cmd_wr[1 - n] && deep_sleep &&
                           reg_wdata_in[2:0] == `RSCI_CMD_OFF;
      // every read of a status address clears it, single or burst, except baseband status in raw sample mode
      assign rf_clr[n] = reg_rd_in && reg_addr_in == (`RSCI_OFS_RF_STATUS0 + 8'(n));
      assign bb_clr[n] = reg_rd_in && reg_addr_in == (`RSCI_OFS_BB_STATUS0 + 8'(n));

      rsci_radio_fsm u_fsm (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .cmd_wr_in(cmd_wr[n]),
        .cmd_in(reg_wdata_in[2:0]),
        .wake_all_in(wake_all[n]),
        .state_out(state[n]),
        .asleep_out(asleep[n]),
        .wake_evt_out(wake_evt[n]),
        .ready_evt_out(ready_evt[n])
      );

      // radio event byte; one battery input feeds both radios
      // sync failure counts only in raw sample mode
      assign rf_raw[n] = {2'b00, rf_evt_in[n].sync_fail && raw_mode, rf_evt_in[n].lock_err,
                          low_battery_in, rf_evt_in[n].energy_done, ready_evt[n], wake_evt[n]};
      // mask mode decides whether masked events are recorded
      assign rf_rec[n] = rf_raw[n] & (rf_mask_ff[n] | {8{mask_mode}});
      assign bb_rec[n] = bb_evt_in[n] & (bb_mask_ff[n] | {8{mask_mode}});

      // set wins over the clearing read
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          rf_stat_ff[n] <= 8'h00;
        end else if (ce_in) begin
          rf_stat_ff[n] <= (rf_clr[n] ? 8'h00 : rf_stat_ff[n]) | rf_rec[n];
        end
      end

      // baseband status frozen in raw sample mode, reads still return it
      // gain hold and release displace each other so only the latest shows; both show if they arrive in the same cycle
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          bb_stat_ff[n] <= 8'h00;
        end else if (ce_in && !raw_mode) begin
          bb_stat_ff[n] <= (rf_keep(bb_stat_ff[n], bb_clr[n], bb_rec[n])) | bb_rec[n];
        end
      end

      // sleeping or resetting radio loses its masks, wake stays enabled
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          rf_mask_ff[n] <= `RSCI_RF_MASK_RST;
          bb_mask_ff[n] <= `RSCI_BB_MASK_RST;
        end else if (ce_in) begin
          if (asleep[n]) begin
            rf_mask_ff[n] <= `RSCI_RF_MASK_RST;
            bb_mask_ff[n] <= `RSCI_BB_MASK_RST;
          end else begin
            if (reg_wr_in && reg_addr_in == (`RSCI_OFS_RF_MASK0 + 8'(n))) begin
              rf_mask_ff[n] <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == (`RSCI_OFS_BB_MASK0 + 8'(n))) begin
              bb_mask_ff[n] <= reg_wdata_in;
            end
          end
        end
      end

      // only bits 2:0 store; upper bits stay zero
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cmd_ff[n] <= `RSCI_CMD_RST;
        end else if (ce_in && cmd_wr[n]) begin
          cmd_ff[n] <= {5'b00000, reg_wdata_in[2:0]};
        end
      end

      // wake mask bit held at 1 while asleep
      chk_wake_mask_forced: assert property (@(posedge clock_in) disable iff (!resetn_in)
        ce_in && asleep[n] |=> rf_mask_ff[n][`RSCI_RF_WAKE])
        else $error("wake mask not forced while radio asleep");

      // read with no new event leaves the register empty
      chk_read_clears: assert property (@(posedge clock_in) disable iff (!resetn_in)
        ce_in && rf_clr[n] && rf_rec[n] == 8'h00 |=> rf_stat_ff[n] == 8'h00)
        else $error("radio status not cleared by read");

      // event coinciding with the clearing read is kept
      chk_set_wins: assert property (@(posedge clock_in) disable iff (!resetn_in)
        ce_in && rf_clr[n] |=> (rf_stat_ff[n] & $past(rf_rec[n])) == $past(rf_rec[n]))
        else $error("event lost during clearing read");

      // masked lock error stays hidden in mask mode 0
      chk_masked_hidden: assert property (@(posedge clock_in) disable iff (!resetn_in)
        ce_in && !mask_mode && !rf_mask_ff[n][`RSCI_RF_LOCKERR] &&
        !rf_stat_ff[n][`RSCI_RF_LOCKERR] |=> !rf_stat_ff[n][`RSCI_RF_LOCKERR])
        else $error("masked event recorded with mask mode 0");

      // baseband status unchanged in raw sample mode
      chk_bb_frozen_raw: assert property (@(posedge clock_in) disable iff (!resetn_in)
        raw_mode |=> $stable(bb_stat_ff[n]))
        else $error("baseband status changed in raw sample mode");

      // sync failure only rises in raw sample mode
      chk_sync_raw_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $rose(rf_stat_ff[n][`RSCI_RF_SYNCFAIL]) |-> $past(raw_mode))
        else $error("sync failure flagged outside raw sample mode");
    end
  endgenerate

  // clear-on-read keep term with gain hold/release exclusivity
  function automatic rsci_byte_t rf_keep(input rsci_byte_t cur, input logic clr,
                                         input rsci_byte_t rec);
    rsci_byte_t k;
    k = clr ? 8'h00 : cur;
    if (rec[`RSCI_BB_GHOLD]) k[`RSCI_BB_GREL] = 1'b0;
    if (rec[`RSCI_BB_GREL]) k[`RSCI_BB_GHOLD] = 1'b0;
    return k;
  endfunction

  // configuration register: raw sample mode and mask mode
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_ff <= `RSCI_CFG_RST;
    end else if (ce_in && reg_wr_in && reg_addr_in == `RSCI_OFS_CFG) begin
      cfg_ff <= reg_wdata_in & 8'h09; // only the two defined bits store
    end
  end

  // read data registered one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      case (reg_addr_in)
        `RSCI_OFS_RF_STATUS0: rdata_ff <= rf_stat_ff[0];
        `RSCI_OFS_RF_STATUS1: rdata_ff <= rf_stat_ff[1];
        `RSCI_OFS_BB_STATUS0: rdata_ff <= bb_stat_ff[0];
        `RSCI_OFS_BB_STATUS1: rdata_ff <= bb_stat_ff[1];
        `RSCI_OFS_CFG: rdata_ff <= cfg_ff;
        `RSCI_OFS_RF_MASK0: rdata_ff <= rf_mask_ff[0];
        `RSCI_OFS_RF_MASK1: rdata_ff <= rf_mask_ff[1];
        `RSCI_OFS_BB_MASK0: rdata_ff <= bb_mask_ff[0];
        `RSCI_OFS_BB_MASK1: rdata_ff <= bb_mask_ff[1];
        `RSCI_OFS_STATE0: rdata_ff <= {5'b00000, state[0]};
        `RSCI_OFS_STATE1: rdata_ff <= {5'b00000, state[1]};
        `RSCI_OFS_CMD0: rdata_ff <= cmd_ff[0];
        `RSCI_OFS_CMD1: rdata_ff <= cmd_ff[1];
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // one pin for all four sources, held while any enabled bit pends
  assign nxt_irq = |(rf_stat_ff[0] & rf_mask_ff[0]) | |(rf_stat_ff[1] & rf_mask_ff[1]) |
                   |(bb_stat_ff[0] & bb_mask_ff[0]) | |(bb_stat_ff[1] & bb_mask_ff[1]);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_ff <= 1'b0;
    end else if (ce_in) begin
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign irq_out = irq_ff;

  // pin follows enabled pending events one cycle later
  chk_irq_follows: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ce_in |=> irq_out == $past(nxt_irq))
    else $error("interrupt pin does not match pending enabled events");

  // low battery lands in both radio registers together
  chk_low_battery_pair: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ce_in && low_battery_in && (mask_mode || (rf_mask_ff[0][3] && rf_mask_ff[1][3]))
    |=> rf_stat_ff[0][`RSCI_RF_LOW_BATTERY] && rf_stat_ff[1][`RSCI_RF_LOW_BATTERY])
    else $error("low battery not flagged in both radios");

  // command register upper bits read zero
  chk_cmd_upper_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
    cmd_ff[0][7:3] == 5'b00000 && cmd_ff[1][7:3] == 5'b00000)
    else $error("command register upper bits not zero");
endmodule // rsci_top

// [rsci_host_model.sv]
/*
  Host-side register master model for the radio state and event block.
  Assumes one-cycle strobes taken on the rising edge of clock_in.
*/
`include "rsci_defs.svh"

module rsci_host_model (
  input wire logic clock_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle from time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // one bus cycle just after the edge; released lines flip so stale values never look valid
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #2;
    reg_wr_out = w;
    reg_rd_out = r;
    reg_addr_out = (w || r) ? a : ~reg_addr_out;
    reg_wdata_out = (w || r) ? d : ~reg_wdata_out;
  endtask

  // legal command codes
  // code 6 is never issued to a command register; gap lets the host answer slowly
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input int gap);
    if (!((a == `RSCI_OFS_CMD0 || a == `RSCI_OFS_CMD1) && d[2:0] == 3'h6)) begin
      xfer(1'b1, 1'b0, a, d);
    end
    repeat (gap + 1) xfer(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // single read, strobe released after one cycle
  task automatic reg_read(input logic [7:0] a);
    xfer(1'b0, 1'b1, a, 8'h00);
    xfer(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // status burst
  // the four status registers read on consecutive cycles
  task automatic burst();
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 1'b1, 8'(i), 8'h00);
    end
    xfer(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
endmodule // rsci_host_model

// [tb_radio_state_cmd_irq_aggregator.sv]
/*
  Self-checking bench for the radio state and event block.
  Assumes rsci_top with one-cycle read data latency and a host model.
*/
`include "rsci_defs.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb_radio_state_cmd_irq_aggregator import rsci_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  logic clock_in = 1'b0;
  logic resetn, ce, reg_wr, reg_rd, irq, low_battery, take_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_v, e0, e1, m;
  rsci_rf_evt_s [1:0] rf_evt;
  logic [1:0][7:0] bb_evt;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int seed = 32'h65fb;

  // 25 MHz clock
  initial forever #20 clock_in = ~clock_in;

  rsci_top i_rsci_top (.clock_in(clock_in), .resetn_in(resetn), .ce_in(ce),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .rf_evt_in(rf_evt), .low_battery_in(low_battery), .bb_evt_in(bb_evt),
    .reg_rdata_out(reg_rdata), .irq_out(irq));

  rsci_host_model i_rsci_host_model (.clock_in(clock_in), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_rsci_host_model.reg_read(a);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_rsci_host_model.reg_write(a, d, 0);
  endtask

  // event pulses last exactly one cycle
  task automatic pulse(input logic [5:0] rf, input logic bl, input logic [7:0] b0,
                       input logic [7:0] b1);
    @(posedge clock_in);
    #2;
    rf_evt = rf;
    low_battery = bl;
    bb_evt = {b1, b0};
    @(posedge clock_in);
    #2;
    rf_evt = '0;
    low_battery = 1'b0;
    bb_evt = '0;
  endtask

  // land just past the edge so registered outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic tdone(input string s);
    $display("test %s finished, %0d checks so far", s, tests_run);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read data lands one edge after the strobe; the oldest note is the one due
  always @(posedge clock_in) begin
    take_rd = reg_rd && ce && resetn;
    #1;
    if (take_rd) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  end

  // a hang is cut short well past the expected length of under a thousand cycles
  initial begin
    #(40 * 5000);
    fail_count++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    rf_evt = '0;
    low_battery = 1'b0;
    bb_evt = '0;
    repeat (12) @(posedge clock_in);
    #2 resetn = 1'b1;
    wt(12);
    `CHK(irq, 1'b1)
    rd(`RSCI_OFS_STATE0, 8'h02);
    rd(`RSCI_OFS_STATE1, 8'h02);
    rd(`RSCI_OFS_RF_STATUS0, 8'h01);
    rd(`RSCI_OFS_RF_STATUS1, 8'h01);
    rd(`RSCI_OFS_RF_MASK0, `RSCI_RF_MASK_RST);
    rd(`RSCI_OFS_BB_MASK0, `RSCI_BB_MASK_RST);
    rd(`RSCI_OFS_CMD0, `RSCI_CMD_RST);
    rd(`RSCI_OFS_RF_STATUS0, 8'h00);
    wt(2);
    `CHK(irq, 1'b0)
    tdone("reset");
    // command sequencing, mask mode on, radio 0 events blocked from the pin
    wr(`RSCI_OFS_CFG, 8'h08);
    wr(`RSCI_OFS_RF_MASK0, 8'h00);
    wr(`RSCI_OFS_CMD0, 8'h03);
    wt(2);
    rd(`RSCI_OFS_STATE0, 8'h06);
    wt(10);
    `CHK(irq, 1'b0)
    rd(`RSCI_OFS_STATE0, 8'h03);
    rd(`RSCI_OFS_RF_STATUS0, 8'h02);
    wr(`RSCI_OFS_CMD0, 8'hFC);
    wt(10);
    rd(`RSCI_OFS_STATE0, 8'h04);
    rd(`RSCI_OFS_CMD0, 8'h04);
    wr(`RSCI_OFS_CMD0, 8'h05);
    wt(10);
    rd(`RSCI_OFS_STATE0, 8'h05);
    wr(`RSCI_OFS_CMD0, 8'h03);
    wr(`RSCI_OFS_CMD0, 8'h04);
    wt(20);
    rd(`RSCI_OFS_STATE0, 8'h04);
    rd(`RSCI_OFS_RF_STATUS0, 8'h02);
    wr(`RSCI_OFS_CMD0, 8'h00);
    wt(10);
    rd(`RSCI_OFS_STATE0, 8'h04);
    wr(`RSCI_OFS_CMD0, 8'h02);
    wt(10);
    rd(`RSCI_OFS_STATE0, 8'h02);
    tdone("commands");
    // deep sleep, wake through one radio, then plain sleep of radio 0
    wr(`RSCI_OFS_CMD0, 8'h01);
    wr(`RSCI_OFS_CMD1, 8'h01);
    wt(12);
    wr(`RSCI_OFS_RF_MASK0, 8'h00);
    rd(`RSCI_OFS_STATE0, 8'h07);
    rd(`RSCI_OFS_STATE1, 8'h07);
    rd(`RSCI_OFS_RF_MASK0, 8'h01);
    wr(`RSCI_OFS_CMD1, 8'h02);
    wt(30);
    `CHK(irq, 1'b1)
    rd(`RSCI_OFS_STATE0, 8'h02);
    rd(`RSCI_OFS_RF_STATUS0, 8'h01);
    rd(`RSCI_OFS_RF_STATUS1, 8'h01);
    wr(`RSCI_OFS_CMD0, 8'h01);
    wt(12);
    wr(`RSCI_OFS_CMD0, 8'h02);
    wt(12);
    rd(`RSCI_OFS_RF_STATUS0, 8'h01);
    rd(`RSCI_OFS_RF_STATUS1, 8'h00);
    // single radio reset
    wr(`RSCI_OFS_RF_MASK1, 8'hFF);
    wr(`RSCI_OFS_CMD1, 8'h07);
    wt(20);
    rd(`RSCI_OFS_STATE1, 8'h02);
    rd(`RSCI_OFS_RF_MASK1, 8'h01);
    rd(`RSCI_OFS_RF_STATUS1, 8'h01);
    rd(`RSCI_OFS_RF_STATUS0, 8'h00);
    tdone("sleep and reset");
    // low battery lands in both radios; only radio 0 lets it reach the pin
    wr(`RSCI_OFS_CFG, 8'h08);
    wr(`RSCI_OFS_RF_MASK0, 8'h08);
    wr(`RSCI_OFS_RF_MASK1, 8'h00);
    pulse(6'h00, 1'b1, 8'h00, 8'h00);
    wt(3);
    `CHK(irq, 1'b1)
    rd(`RSCI_OFS_RF_STATUS0, 8'h08);
    wt(3);
    `CHK(irq, 1'b0)
    rd(`RSCI_OFS_RF_STATUS1, 8'h08);
    // energy event in the very cycle of the clearing read
    exp_q.push_back(8'h00);
    i_rsci_host_model.xfer(1'b0, 1'b1, `RSCI_OFS_RF_STATUS0, 8'h00);
    rf_evt = 6'h01;
    i_rsci_host_model.xfer(1'b0, 1'b0, 8'h00, 8'h00);
    rf_evt = '0;
    rd(`RSCI_OFS_RF_STATUS0, 8'h04);
    tdone("events");
    // raw sample mode against mask mode off, random events and masks
    repeat (4) begin
      e0 = 8'($random(seed)) & 8'hB8;
      m = 8'($random(seed));
      wr(`RSCI_OFS_CFG, 8'h09);
      wr(`RSCI_OFS_BB_MASK0, m);
      pulse(6'h04, 1'b0, e0, 8'h00);
      wt(2);
      rd(`RSCI_OFS_RF_STATUS0, 8'h20);
      rd(`RSCI_OFS_BB_STATUS0, 8'h00);
      wr(`RSCI_OFS_CFG, 8'h00);
      wr(`RSCI_OFS_RF_MASK0, 8'h20);
      // masked lock error and energy plus sync failure outside raw sample mode
      pulse(6'h07, 1'b0, e0, 8'h00);
      wt(3);
      `CHK(irq, |(e0 & m))
      rd(`RSCI_OFS_RF_STATUS0, 8'h00);
      rd(`RSCI_OFS_BB_STATUS0, e0 & m);
    end
    tdone("modes");
    // all four status registers in one burst, then again to see them cleared
    e0 = 8'($random(seed)) & 8'hB8;
    e1 = 8'($random(seed)) & 8'hB8;
    wr(`RSCI_OFS_CFG, 8'h08);
    pulse(6'h10, 1'b1, e0, e1);
    wt(2);
    exp_q.push_back(8'h08);
    exp_q.push_back(8'h18);
    exp_q.push_back(e0);
    exp_q.push_back(e1);
    i_rsci_host_model.burst();
    repeat (4) exp_q.push_back(8'h00);
    i_rsci_host_model.burst();
    rd(8'h7F, 8'h00);
    // a write with the clock enable low must leave the radio alone
    ce = 1'b0;
    wr(`RSCI_OFS_CMD0, 8'h03);
    ce = 1'b1;
    wt(10);
    rd(`RSCI_OFS_STATE0, 8'h02);
    tdone("burst");
    test_done();
  end
endmodule // tb_radio_state_cmd_irq_aggregator
